// ---- logic/refctl_defines.vh ----
// constants for the reference setup control block
// Function
// - reference code 00 internal for both; others external dac, adc per code
// - internal-reference adc modes power reference down after scan completes
// - internal clock modes: reference off, wait 218 conversion clocks before converting
// - temperature always uses internal reference; wait 244 conversion clocks after wake
// - external adc reference modes keep internal reference off for input conversions
// - external clock mode: input conversion wake wait is 218 serial clocks
// - external clock mode: temperature waits 244, output starts 188 clocks later
// - reference code 10 is the mode in force after reset
// - target 00/01: no data byte, polarity registers unchanged
// - target 10: next byte stored in unipolar register
// - target 11: next byte stored in bipolar register
// - setup byte has bit7 zero, bit6 one; fields clock, reference, target
// - clock mode 11 times from serial clock; others use internal oscillator
// - after target 00/01 the next byte is decoded as a command
`ifndef REFCTL_DEFINES_VH
`define REFCTL_DEFINES_VH
`define SETUP_ID_HI 7
`define SETUP_ID_LO 6
`define CLK_MODE_HI 5
`define CLK_MODE_LO 4
`define REF_SEL_HI 3
`define REF_SEL_LO 2
`define TGT_HI 1
`define TGT_LO 0
`define REF_INT_BOTH 2'h0
`define REF_EXT_SE 2'h1
`define REF_INT_ADC 2'h2
`define REF_EXT_DIFF 2'h3
`define CLK_MODE_RESET 2'h2
`define CLK_MODE_EXT 2'h3
`define TGT_UNI 2'h2
`define TGT_BI 2'h3
`define AIN_WAKE_CYC 16'h00da
`define TEMP_WAKE_CYC 16'h00f4
`define TEMP_OUT_CYC 16'h00bc
`define POL_RESET 8'h00
`endif

// ---- logic/sync2.v ----
// two-flop synchroniser
`timescale 1ns/1ps
module sync2 (
    input wire clk,
    input wire rst,
    input wire d,
    output wire q
);
    reg s1_q;
    reg s2_q;
    // first flop feeds only the second
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule // sync2

// ---- logic/tick_counter.v ----
// down counter of tick events with done pulse
`timescale 1ns/1ps
module tick_counter #(
    parameter W = 16
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [W-1:0] count,
    input wire tick,
    output wire busy,
    output reg done
);
    reg [W-1:0] cnt_q;
    reg run_q;
    assign busy = run_q;
    // load, count ticks, pulse done at zero
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
            run_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_q <= count;
                run_q <= 1'b1;
            end else if (run_q && tick) begin
                if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
                    run_q <= 1'b0;
                    done <= 1'b1;
                    cnt_q <= {W{1'b0}};
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // tick_counter

// ---- logic/adc_reference_setup_control.v ----
// reference mode, wake-up timing and polarity register control
`timescale 1ns/1ps
`include "refctl_defines.vh"
module adc_reference_setup_control (
    input wire clk,
    input wire rst,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire frame_end,
    input wire sclk_pin,
    input wire int_osc_tick,
    input wire conv_req,
    input wire temp_req,
    input wire scan_done,
    output reg [1:0] clock_mode,
    output wire clock_mode_select_hi,
    output wire clock_mode_select_lo,
    output reg [1:0] ref_mode,
    output wire reference_select_hi,
    output wire reference_select_lo,
    output wire use_ext_clock,
    output reg [7:0] unipolar_cfg,
    output reg [7:0] bipolar_cfg,
    output reg int_ref_on,
    output reg adc_use_int_ref,
    output reg adc_use_ext_diff,
    output reg dac_use_int_ref,
    output reg conv_start,
    output reg temp_start,
    output reg temp_out_start,
    output wire waiting,
    output reg expect_data
);
    localparam ST_IDLE = 3'h0;
    localparam ST_WAKE_AIN = 3'h1;
    localparam ST_WAKE_TEMP = 3'h2;
    localparam ST_CONV = 3'h3;
    localparam ST_TEMP = 3'h4;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] target_q;
    reg sclk_prev_q;
    wire sclk_s;
    wire sclk_rise;
    wire tick;
    wire is_setup;
    wire wake_done;
    wire wake_busy;
    wire out_done;
    wire out_busy;
    reg wake_load;
    reg [15:0] wake_count;
    reg out_load;

    // serial clock pin synchronised before edge detection
    sync2 u_sclk_sync (
        .clk(clk),
        .rst(rst),
        .d(sclk_pin),
        .q(sclk_s)
    );

    always @(posedge clk) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_prev_q;

    // clock source for delays
    assign use_ext_clock = (clock_mode == `CLK_MODE_EXT);
    assign tick = use_ext_clock ? sclk_rise : int_osc_tick;

    assign clock_mode_select_hi = clock_mode[1];
    assign clock_mode_select_lo = clock_mode[0];
    assign reference_select_hi = ref_mode[1];
    assign reference_select_lo = ref_mode[0];

    // setup byte decode
    assign is_setup = byte_valid && !expect_data
        && !byte_data[`SETUP_ID_HI] && byte_data[`SETUP_ID_LO];

    // setup fields and polarity registers
    always @(posedge clk) begin
        if (rst) begin
            clock_mode <= `CLK_MODE_RESET;
            ref_mode <= `REF_INT_ADC;
            unipolar_cfg <= `POL_RESET;
            bipolar_cfg <= `POL_RESET;
            expect_data <= 1'b0;
            target_q <= 2'h0;
        end else if (expect_data) begin
            if (byte_valid) begin
                expect_data <= 1'b0;
                if (target_q == `TGT_UNI) begin
                    unipolar_cfg <= byte_data;
                end else begin
                    bipolar_cfg <= byte_data;
                end
            end else if (frame_end) begin
                expect_data <= 1'b0;
            end
        end else if (is_setup) begin
            clock_mode <= byte_data[`CLK_MODE_HI:`CLK_MODE_LO];
            ref_mode <= byte_data[`REF_SEL_HI:`REF_SEL_LO];
            target_q <= byte_data[`TGT_HI:`TGT_LO];
            // only targets 10 and 11 take a data byte
            expect_data <= byte_data[`TGT_HI];
        end
    end

    // reference routing per mode
    always @* begin
        dac_use_int_ref = (ref_mode == `REF_INT_BOTH);
        adc_use_int_ref = (ref_mode == `REF_INT_BOTH) || (ref_mode == `REF_INT_ADC);
        adc_use_ext_diff = (ref_mode == `REF_EXT_DIFF);
        if (state_q == ST_WAKE_TEMP || state_q == ST_TEMP) begin
            adc_use_int_ref = 1'b1;
            adc_use_ext_diff = 1'b0;
        end
    end

    tick_counter #(.W(16)) u_wake (
        .clk(clk),
        .rst(rst),
        .load(wake_load),
        .count(wake_count),
        .tick(tick),
        .busy(wake_busy),
        .done(wake_done)
    );

    tick_counter #(.W(16)) u_tout (
        .clk(clk),
        .rst(rst),
        .load(out_load),
        .count(`TEMP_OUT_CYC),
        .tick(sclk_rise),
        .busy(out_busy),
        .done(out_done)
    );

    assign waiting = wake_busy;

    // sequencing state machine
    always @* begin
        state_d = state_q;
        wake_load = 1'b0;
        wake_count = `AIN_WAKE_CYC;
        out_load = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (temp_req) begin
                    if (int_ref_on) begin
                        state_d = ST_TEMP;
                    end else begin
                        wake_load = 1'b1;
                        wake_count = `TEMP_WAKE_CYC;
                        state_d = ST_WAKE_TEMP;
                    end
                end else if (conv_req) begin
                    if (!adc_use_int_ref || int_ref_on) begin
                        state_d = ST_CONV;
                    end else begin
                        wake_load = 1'b1;
                        wake_count = `AIN_WAKE_CYC;
                        state_d = ST_WAKE_AIN;
                    end
                end
            end
            ST_WAKE_AIN: begin
                if (wake_done) begin
                    state_d = ST_CONV;
                end
            end
            ST_WAKE_TEMP: begin
                if (wake_done) begin
                    state_d = ST_TEMP;
                end
            end
            ST_CONV: begin
                if (scan_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_TEMP: begin
                out_load = use_ext_clock;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state, start pulses and reference power
    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            conv_start <= 1'b0;
            temp_start <= 1'b0;
            temp_out_start <= 1'b0;
            int_ref_on <= 1'b0;
        end else begin
            state_q <= state_d;
            conv_start <= (state_q != ST_CONV) && (state_d == ST_CONV);
            temp_start <= (state_d == ST_TEMP);
            temp_out_start <= out_done;
            if (wake_load) begin
                int_ref_on <= 1'b1;
            end else if (scan_done && (state_q == ST_CONV || state_q == ST_IDLE)) begin
                int_ref_on <= 1'b0;
            end else if (!adc_int_mode(ref_mode) && state_q != ST_WAKE_TEMP) begin
                // external adc reference: keep it off except while waiting for temperature wake
                int_ref_on <= 1'b0;
            end
        end
    end

    function adc_int_mode;
        input [1:0] m;
        begin
            adc_int_mode = (m == `REF_INT_BOTH) || (m == `REF_INT_ADC);
        end
    endfunction
endmodule // adc_reference_setup_control

// ---- test/refctl_asserts.sv ----
// port checker for the reference setup control
`timescale 1ns/1ps
module refctl_asserts (
    input wire clk,
    input wire rst,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire scan_done,
    input wire conv_req,
    input wire temp_req,
    input wire [1:0] clock_mode,
    input wire [1:0] ref_mode,
    input wire use_ext_clock,
    input wire [7:0] unipolar_cfg,
    input wire [7:0] bipolar_cfg,
    input wire int_ref_on,
    input wire adc_use_int_ref,
    input wire dac_use_int_ref,
    input wire conv_start,
    input wire temp_start,
    input wire waiting,
    input wire expect_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // setup byte outside a pending data byte
    wire setup = byte_valid && !expect_data && byte_data[7:6] == 2'h1;
    property p_ext; use_ext_clock == (clock_mode == 2'h3); endproperty
    a_ext: assert property (p_ext) else $error("clock flag wrong");
    property p_dac; dac_use_int_ref == (ref_mode == 2'h0); endproperty
    a_dac: assert property (p_dac) else $error("dac ref wrong");
    property p_adc;
        adc_use_int_ref == (!ref_mode[0] || temp_start || waiting || $past(waiting));
    endproperty
    a_adc: assert property (p_adc) else $error("adc ref wrong");
    property p_rst; $fell(rst) |-> ref_mode == 2'h2 && clock_mode == 2'h2; endproperty
    a_rst: assert property (p_rst) else $error("reset mode wrong");
    property p_keep; setup && !byte_data[1] |=> $stable(unipolar_cfg) && !expect_data; endproperty
    a_keep: assert property (p_keep) else $error("cfg touched");
    property p_want; setup && byte_data[1] |=> expect_data; endproperty
    a_want: assert property (p_want) else $error("no data wait");
    property p_store;
        byte_valid && expect_data |=> !expect_data &&
            (unipolar_cfg == $past(byte_data) || bipolar_cfg == $past(byte_data));
    endproperty
    a_store: assert property (p_store) else $error("data not stored");
    property p_off;
        scan_done && adc_use_int_ref && !waiting && !conv_req && !temp_req |=> !int_ref_on;
    endproperty
    a_off: assert property (p_off) else $error("ref kept on");
    property p_tref; temp_start |-> int_ref_on; endproperty
    a_tref: assert property (p_tref) else $error("temp without ref");
    property p_xref; conv_start && ref_mode[0] |-> !int_ref_on; endproperty
    a_xref: assert property (p_xref) else $error("ref on for ext");
endmodule // refctl_asserts

// ---- test/host_model.sv ----
// serial host model: command bytes and link clock
`timescale 1ns/1ps
module host_model (
    input wire clk,
    input wire sclk_en,
    output reg byte_valid,
    output reg [7:0] byte_data,
    output reg frame_end,
    output reg sclk_pin
);
    // idle lines, link clock stands still unless enabled
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        frame_end = 1'b0;
        sclk_pin = 1'b0;
        #13;
        forever #200 sclk_pin = sclk_en & ~sclk_pin;
    end
    // one byte for one cycle, released line shows the inverse
    task put(input [7:0] b);
        begin
            @(negedge clk);
            byte_valid = 1'b1;
            byte_data = b;
            @(negedge clk);
            byte_valid = 1'b0;
            byte_data = ~b;
        end
    endtask
    // setup byte, data byte only for targets 10/11, else optional next command
    task send(input [7:0] s, input [7:0] d);
        begin
            put(s);
            if (s[1] || d != 8'h00) put(d);
            @(negedge clk);
            frame_end = 1'b1;
            @(negedge clk);
            frame_end = 1'b0;
        end
    endtask
endmodule // host_model

// ---- test/adc_reference_setup_control_tb.sv ----
// self-checking bench for the reference setup control
`timescale 1ns/1ps
module adc_reference_setup_control_tb;
    reg clk = 0, rst = 1, int_osc_tick = 0, conv_req = 0, temp_req = 0;
    reg scan_done = 0, sclk_en = 0, tick_en = 1, ext = 0, sp = 0;
    wire byte_valid, frame_end, sclk_pin, int_ref_on, dac_use_int_ref;
    wire conv_start, temp_start, temp_out_start;
    wire [7:0] byte_data, unipolar_cfg, bipolar_cfg;
    wire [1:0] clock_mode, ref_mode;
    logic [11:0] expq[$];
    logic [8:0] cnt = 0;
    logic [7:0] d;
    integer fails = 0, tests_run = 0, k, tk = 0;
    wire [11:0] ev = {conv_start, temp_start, temp_out_start, cnt};
    always #25 clk = ~clk;
    adc_reference_setup_control i_dut (.clk, .rst, .byte_valid, .byte_data, .frame_end,
        .sclk_pin, .int_osc_tick, .conv_req, .temp_req, .scan_done, .clock_mode,
        .clock_mode_select_hi(), .clock_mode_select_lo(), .ref_mode, .reference_select_hi(),
        .reference_select_lo(), .use_ext_clock(), .unipolar_cfg, .bipolar_cfg, .int_ref_on,
        .adc_use_int_ref(), .adc_use_ext_diff(), .dac_use_int_ref, .conv_start, .temp_start,
        .temp_out_start, .waiting(), .expect_data());
    host_model i_host (.clk, .sclk_en, .byte_valid, .byte_data, .frame_end, .sclk_pin);
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        begin
            tests_run++;
            if (seen !== exp) begin
                fails++;
                $display("FAIL %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // internal conversion clock every 8 cycles
    always @(negedge clk) begin
        tk <= tk + 1;
        int_osc_tick <= tick_en && tk % 8 == 0;
    end
    // counts wake clocks, takes oldest note at each start pulse
    always @(posedge clk) begin
        sp <= sclk_pin;
        if (conv_req || temp_req) cnt <= 0;
        else if (conv_start || temp_start || temp_out_start) begin
            if (expq.size() == 0) chk(1, 0, "extra event");
            else chk(ev, expq.pop_front(), "event");
            cnt <= 0;
        end else if (ext ? sclk_pin & ~sp : int_osc_tick) cnt <= cnt + 1;
    end
    // one request pulse away from ticks, then bounded wait for its events
    task req(input t, input [11:0] e, input [11:0] e2);
        begin
            expq.push_back(e);
            if (e2 != 0) expq.push_back(e2);
            while (tk % 8 != 4) @(negedge clk);
            {temp_req, conv_req} = t ? 2'b10 : 2'b01;
            @(negedge clk);
            {temp_req, conv_req} = 2'b00;
            for (k = 0; k < 9000 && expq.size() > 0; k++) @(negedge clk);
        end
    endtask
    task scan;
        begin
            @(negedge clk) scan_done = 1;
            @(negedge clk) scan_done = 0;
            @(negedge clk);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        fails++;
        conclude;
    end
    initial begin
        d = $urandom(7732);
        repeat (5) @(negedge clk);
        rst = 0;
        @(negedge clk);
        chk({ref_mode, clock_mode, unipolar_cfg}, 12'ha00, "reset");
        for (k = 0; k < 4; k++) begin
            d = $urandom;
            i_host.send({4'h6, k[1:0], 2'h2}, d);
            i_host.send({4'h6, k[1:0], 2'h3}, ~d);
            chk({unipolar_cfg, bipolar_cfg}, {d, ~d}, "cfg");
            chk({ref_mode, dac_use_int_ref}, {k[1:0], k == 0}, "ref");
        end
        i_host.send(8'h65, 8'h68);
        chk({unipolar_cfg, bipolar_cfg}, {d, ~d}, "keep");
        chk(ref_mode, 2'h2, "next cmd");
        req(0, 12'h8da, 0);
        chk(int_ref_on, 1, "ref up");
        scan;
        chk(int_ref_on, 0, "ref down");
        req(1, 12'h4f4, 0);
        tick_en = 0;
        req(0, 12'h800, 0);
        scan;
        i_host.send(8'h64, 0);
        req(0, 12'h800, 0);
        chk(int_ref_on, 0, "ext ref");
        scan;
        i_host.send(8'h78, 0);
        ext = 1;
        sclk_en = 1;
        req(0, 12'h8da, 0);
        scan;
        req(1, 12'h4f4, 12'h2bc);
        chk(expq.size(), 0, "left over");
        conclude;
    end
endmodule // adc_reference_setup_control_tb
bind adc_reference_setup_control refctl_asserts i_chk (.*);
